// File: dv/flp_host.sv
// programmer or isp host model driving the request port
`timescale 1ns/1ps
`default_nettype none
module flp_host (
  input wire logic clk,
  output var flp_pkg::flp_req_t req,
  input wire flp_pkg::flp_rsp_t rsp,
  input wire logic flash_wr_en,
  input wire logic flash_erase_all
);
  import flp_pkg::*;
  // ====
  // idle request, valid low
  initial req = '0;
  // one request a call; answer taken the cycle after
  task automatic xfer(input flp_op_t op, input flp_src_t src, input logic [1:0] idx,
                      input logic [7:0] d, output flp_rsp_t r, output logic [1:0] s);
    @(posedge clk);
    #1;
    // reserved loader lock bits always sent as one
    req = '{valid: 1'b1, op: op, src: src, xfp_idx: idx,
            wdata: (idx == XFP_LLB) ? (d | LLB_RSVD_MASK) : d};
    @(posedge clk);
    #1;
    r = rsp;
    s = {flash_wr_en, flash_erase_all};
    // released fields scrambled so stale values cannot pass
    req = {1'b0, ~req[14:0]};
  endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the flash lock block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
  import flp_pkg::*;
  // ====
  logic clk, rst_n, mem_32k, code_source_select, table_read_ext;
  logic [15:0] pc, reset_vector;
  flp_req_t req;
  flp_rsp_t rsp;
  logic flash_wr_en, flash_erase_all, fetch_external, table_read_block;
  logic ext_exec_fault, aux_ram_en, double_speed;
  logic [7:0] fuse_security_byte, loader_lock_byte, boot_status_byte, boot_vector_high;
  logic [7:0] rdat; // last read data
  int fail_count, n_tests;
  flp_lock i_flp_lock (.clk, .rst_n, .mem_32k, .code_source_select, .pc, .table_read_ext,
    .req, .rsp, .flash_wr_en, .flash_erase_all, .fetch_external, .table_read_block,
    .ext_exec_fault, .reset_vector, .aux_ram_en, .double_speed, .fuse_security_byte,
    .loader_lock_byte, .boot_status_byte, .boot_vector_high);
  flp_host i_flp_host (.clk, .req, .rsp, .flash_wr_en, .flash_erase_all);
  // ====
  // one transfer; strobes judged only when sc set
  task automatic run(input flp_op_t op, input flp_src_t src, input logic [1:0] idx,
                     input logic [7:0] d, input logic g, input logic sc, input logic [1:0] st);
    flp_rsp_t r;
    logic [1:0] s;
    i_flp_host.xfer(op, src, idx, d, r, s);
    `CHK({r.done, r.granted, sc ? s : st}, {1'b1, g, st})
    rdat = r.rdata;
  endtask
  // fetch setup, result registered one cycle on
  task automatic fetch(input logic m, input logic e, input logic [15:0] a);
    mem_32k = m;
    code_source_select = e;
    pc = a;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    repeat (2) @(posedge clk);
    #1;
    `CHK({fuse_security_byte, loader_lock_byte, boot_status_byte}, 24'hABFFFF)
    `CHK(boot_vector_high, 8'hFC)
    `CHK({reset_vector, aux_ram_en, double_speed}, {16'hF800, 2'b10})
  endtask
  task automatic t_lvl4;
    run(FLP_OP_PROG, FLP_SRC_PAR, 2'h0, 8'h5A, 1'b0, 1'b1, 2'b00);
    run(FLP_OP_VERIFY, FLP_SRC_PAR, 2'h0, 8'h00, 1'b0, 1'b1, 2'b00);
    run(FLP_OP_ID, FLP_SRC_PAR, 2'h0, 8'h00, 1'b1, 1'b1, 2'b00);
    `CHK(rdat, 8'h3C)
    run(FLP_OP_PROG, FLP_SRC_ISP, 2'h0, 8'h5A, 1'b1, 1'b1, 2'b10);
    run(FLP_OP_PROG, FLP_SRC_API, 2'h0, 8'h5A, 1'b1, 1'b1, 2'b10);
    table_read_ext = 1'b1;
    fetch(1'b1, 1'b1, 16'h8000);
    `CHK({ext_exec_fault, table_read_block}, 2'b11)
  endtask
  task automatic t_erase;
    run(FLP_OP_ERASE, FLP_SRC_PAR, 2'h0, 8'h00, 1'b1, 1'b1, 2'b01);
    fetch(1'b1, 1'b1, 16'h0000);
    `CHK({fuse_security_byte, reset_vector}, 24'hFF0000)
    `CHK({table_read_block, ext_exec_fault}, 2'b00)
    run(FLP_OP_PROG, FLP_SRC_PAR, 2'h0, 8'hA5, 1'b1, 1'b1, 2'b10);
    run(FLP_OP_VERIFY, FLP_SRC_PAR, 2'h0, 8'h00, 1'b1, 1'b1, 2'b00);
  endtask
  task automatic t_map;
    fetch(1'b0, 1'b1, 16'h3FFF);
    `CHK(fetch_external, 1'b0)
    fetch(1'b0, 1'b1, 16'h4000);
    `CHK(fetch_external, 1'b1)
    fetch(1'b1, 1'b1, 16'h7FFF);
    `CHK(fetch_external, 1'b0)
    fetch(1'b1, 1'b1, 16'h8000);
    `CHK(fetch_external, 1'b1)
    fetch(1'b1, 1'b0, 16'h0000);
    `CHK(fetch_external, 1'b1)
  endtask
  task automatic t_bsb;
    // host clears boot status after isp loading
    run(FLP_OP_XFP_WR, FLP_SRC_ISP, XFP_BSB, 8'h00, 1'b1, 1'b0, 2'b00);
    run(FLP_OP_XFP_RD, FLP_SRC_PAR, XFP_BSB, 8'h00, 1'b1, 1'b0, 2'b00);
    `CHK({rdat, boot_status_byte}, 16'h0000)
    run(FLP_OP_XFP_WR, FLP_SRC_API, XFP_BVH, 8'h80, 1'b1, 1'b0, 2'b00);
    run(FLP_OP_XFP_RD, FLP_SRC_ISP, XFP_BVH, 8'h00, 1'b1, 1'b0, 2'b00);
    `CHK({rdat, boot_vector_high}, 16'h8080)
  endtask
  task automatic t_fuse;
    // levels set only after verify passed above
    run(FLP_OP_XFP_WR, FLP_SRC_PAR, XFP_FSB, 8'hFE, 1'b1, 1'b0, 2'b00);
    run(FLP_OP_VERIFY, FLP_SRC_PAR, 2'h0, 8'h00, 1'b1, 1'b1, 2'b00);
    run(FLP_OP_PROG, FLP_SRC_PAR, 2'h0, 8'h11, 1'b0, 1'b1, 2'b00);
    // also programs the double speed and aux ram fuses
    run(FLP_OP_XFP_WR, FLP_SRC_PAR, XFP_FSB, 8'h75, 1'b1, 1'b0, 2'b00);
    run(FLP_OP_XFP_WR, FLP_SRC_ISP, XFP_FSB, 8'h00, 1'b0, 1'b0, 2'b00);
    `CHK(fuse_security_byte, 8'h74)
    run(FLP_OP_XFP_RD, FLP_SRC_ISP, XFP_FSB, 8'h00, 1'b1, 1'b0, 2'b00);
    `CHK(rdat, 8'h74)
    run(FLP_OP_VERIFY, FLP_SRC_PAR, 2'h0, 8'h00, 1'b0, 1'b1, 2'b00);
    run(FLP_OP_PROG, FLP_SRC_ISP, 2'h0, 8'h22, 1'b1, 1'b1, 2'b10);
    // pin latched high at reset, live low ignored
    fetch(1'b1, 1'b0, 16'h0000);
    `CHK(fetch_external, 1'b0)
    `CHK({aux_ram_en, double_speed}, 2'b01)
    fetch(1'b1, 1'b1, 16'h8000);
    `CHK({fetch_external, ext_exec_fault, table_read_block}, 3'b101)
  endtask
  task automatic t_llb;
    run(FLP_OP_XFP_WR, FLP_SRC_ISP, XFP_LLB, 8'hFE, 1'b1, 1'b0, 2'b00);
    run(FLP_OP_PROG, FLP_SRC_ISP, 2'h0, 8'h33, 1'b0, 1'b1, 2'b00);
    run(FLP_OP_VERIFY, FLP_SRC_ISP, 2'h0, 8'h00, 1'b1, 1'b1, 2'b00);
    run(FLP_OP_PROG, FLP_SRC_API, 2'h0, 8'h44, 1'b1, 1'b1, 2'b10);
    run(FLP_OP_XFP_WR, FLP_SRC_API, XFP_LLB, 8'h01, 1'b1, 1'b0, 2'b00);
    `CHK(loader_lock_byte, 8'hFC)
    run(FLP_OP_XFP_RD, FLP_SRC_PAR, XFP_LLB, 8'h00, 1'b1, 1'b0, 2'b00);
    `CHK(rdat, 8'hFC)
    run(FLP_OP_VERIFY, FLP_SRC_ISP, 2'h0, 8'h00, 1'b0, 1'b1, 2'b00);
    run(FLP_OP_PROG, FLP_SRC_ISP, 2'h0, 8'h55, 1'b0, 1'b1, 2'b00);
  endtask
  // second reset with the pin low; the live pin going high is ignored
  task automatic t_latch;
    code_source_select = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // pin must still be low at the first edge after release
    @(posedge clk);
    #1;
    fetch(1'b1, 1'b1, 16'h0000);
    `CHK({fetch_external, ext_exec_fault}, 2'b11)
    `CHK(fuse_security_byte, 8'hAB)
  endtask
  // ====
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // watchdog, run needs well under 400 cycles
  initial begin
    #20000;
    fail_count++;
    complete_run();
  end
  initial begin
    {rst_n, mem_32k, table_read_ext, pc} = '0;
    code_source_select = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_lvl4();
    // erase always precedes a fresh load
    t_erase();
    t_map();
    t_bsb();
    t_fuse();
    t_llb();
    t_latch();
    complete_run();
  end
endmodule
`default_nettype wire

// File: hw/flp_lock.sv
// flash lock decode, programming gate and fetch mapping
//
// Operation
// - all lock bits one: level 1, no restriction
// - level 2: latch pin; block table read, program
// - level 3 adds parallel verify refusal
// - level 4 default adds no external execution
// - one unprogrammed; highest programmed bit wins
// - chip erase clears fuse byte, erases flash
// - part identification readable at every level
// - fuse byte ships as 101x 1011b
// - fuse locks parallel only; loader lock isp
// - extra page reachable by parallel, isp, api
// - loader lock level 2 refuses isp programming
// - loader lock level 3 refuses isp verify too
// - internal flash fills lowest 16K or 32K
// - pin high: internal until pc passes top
// - pin low: every fetch external
// - loader jump fuse selects F800h or 0000h start
// - aux ram fuse programmed disables expanded ram
// - boot vector defaults FCh
`timescale 1ns/1ps
`default_nettype none
module flp_lock (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mem_32k,                 // memory size strap, 1 = 32K
  input wire logic code_source_select,      // code source pin
  input wire logic [15:0] pc,               // program counter of current fetch
  input wire logic table_read_ext,          // code table read from external code
  input wire flp_pkg::flp_req_t req,        // programming request
  output var flp_pkg::flp_rsp_t rsp,        // programming answer
  output logic flash_wr_en,                 // flash array write strobe
  output logic flash_erase_all,             // whole array erase strobe
  output logic fetch_external,              // fetch goes to external bus
  output logic table_read_block,            // table read returns no internal byte
  output logic ext_exec_fault,              // external fetch forbidden
  output logic [15:0] reset_vector,         // start address
  output logic aux_ram_en,                  // expanded ram enabled
  output logic double_speed,                // double speed mode
  output logic [7:0] fuse_security_byte,
  output logic [7:0] loader_lock_byte,
  output logic [7:0] boot_status_byte,
  output logic [7:0] boot_vector_high
);
  import flp_pkg::*;

  // ======================================================
  // stored fuses and extra page registers
  logic [7:0] next_fsb, next_llb, next_bsb, next_bvh;
  flp_rsp_t next_rsp;
  logic next_wr, next_erase;
  logic pin_latched;        // code source pin caught at reset release
  logic started;            // first cycle after reset seen
  logic next_pin_latched, next_started;
  flp_level_t par_lvl;      // parallel protection level
  flp_level_t isp_lvl;      // isp level, level 4 never used
  logic par_req, isp_req, prog_ok, verify_ok;

  // highest programmed bit selects level, lower bits ignored
  always_comb begin
    if (!fuse_security_byte[FSB_LB_HIGH]) begin
      par_lvl = FLP_LVL4;
    end else if (!fuse_security_byte[FSB_LB_MID]) begin
      par_lvl = FLP_LVL3;
    end else if (!fuse_security_byte[FSB_LB_LOW]) begin
      par_lvl = FLP_LVL2;
    end else begin
      par_lvl = FLP_LVL1;
    end
    if (!loader_lock_byte[LLB_LB_MID]) begin
      isp_lvl = FLP_LVL3;
    end else if (!loader_lock_byte[LLB_LB_LOW]) begin
      isp_lvl = FLP_LVL2;
    end else begin
      isp_lvl = FLP_LVL1;
    end
  end

  // permission decode per source; api is never gated by locks
  always_comb begin
    par_req = (req.src == FLP_SRC_PAR);
    isp_req = (req.src == FLP_SRC_ISP);
    prog_ok = 1'b1;
    verify_ok = 1'b1;
    if (par_req) begin
      prog_ok = (par_lvl == FLP_LVL1);
      verify_ok = (par_lvl == FLP_LVL1) || (par_lvl == FLP_LVL2);
    end else if (isp_req) begin
      prog_ok = (isp_lvl == FLP_LVL1);
      verify_ok = (isp_lvl != FLP_LVL3);
    end
  end

  // request handling; answer one cycle after the request
  always_comb begin
    next_fsb = fuse_security_byte;
    next_llb = loader_lock_byte;
    next_bsb = boot_status_byte;
    next_bvh = boot_vector_high;
    next_rsp = '0;
    next_wr = 1'b0;
    next_erase = 1'b0;
    if (req.valid) begin
      next_rsp.done = 1'b1;
      case (req.op)
        FLP_OP_PROG: begin
          next_rsp.granted = prog_ok;
          next_wr = prog_ok;
        end
        FLP_OP_VERIFY: begin
          next_rsp.granted = verify_ok;
        end
        FLP_OP_ERASE: begin
          // erase always allowed from parallel or isp side
          next_rsp.granted = 1'b1;
          next_erase = 1'b1;
          next_fsb = FSB_ERASED;
          next_llb = LLB_DEFAULT;
        end
        FLP_OP_ID: begin
          next_rsp.granted = 1'b1;
          next_rsp.rdata = PART_ID;
        end
        FLP_OP_XFP_RD: begin
          next_rsp.granted = 1'b1;
          case (req.xfp_idx)
            XFP_FSB: next_rsp.rdata = fuse_security_byte;
            XFP_LLB: next_rsp.rdata = loader_lock_byte;
            XFP_BSB: next_rsp.rdata = boot_status_byte;
            default: next_rsp.rdata = boot_vector_high;
          endcase
        end
        FLP_OP_XFP_WR: begin
          // fuse and loader lock writes program bits only, never back to one; keeps levels one-way
          next_rsp.granted = 1'b1;
          case (req.xfp_idx)
            XFP_FSB: begin
              next_rsp.granted = par_req;  // fuses only via programmer
              if (par_req) begin
                next_fsb = fuse_security_byte & req.wdata;
              end
            end
            XFP_LLB: next_llb = loader_lock_byte & (req.wdata | LLB_RSVD_MASK);
            XFP_BSB: begin
              next_rsp.granted = prog_ok;
              if (prog_ok) begin
                next_bsb = req.wdata;
              end
            end
            default: begin
              next_rsp.granted = prog_ok;
              if (prog_ok) begin
                next_bvh = req.wdata;
              end
            end
          endcase
        end
        default: next_rsp.done = 1'b1;
      endcase
    end
  end

  // ======================================================
  // fetch mapping and reset-sampled pin
  logic [15:0] top_addr;
  logic next_fetch_ext, next_tbl_block, next_ext_fault;
  logic [15:0] next_reset_vector;   // start address, registered one cycle after the fuse byte
  logic next_aux_ram_en, next_double_speed;
  logic eff_pin;
  always_comb begin
    top_addr = mem_32k ? TOP_32K : TOP_16K;
    next_started = 1'b1;
    // pin is latched once after reset at every level; latched value used only at level 2 or above
    next_pin_latched = started ? pin_latched : code_source_select;
    eff_pin = (par_lvl == FLP_LVL1) ? code_source_select : pin_latched;
    if (!eff_pin) begin
      next_fetch_ext = 1'b1;
    end else begin
      next_fetch_ext = (pc > top_addr);
    end
    next_tbl_block = table_read_ext && (par_lvl != FLP_LVL1);
    next_ext_fault = next_fetch_ext && (par_lvl == FLP_LVL4);
    // programmed (zero) jump fuse starts the loader
    next_reset_vector = fuse_security_byte[FSB_LDR_JUMP] ? APP_START_ADDR
                                                         : BOOT_LOADER_ADDR;
    next_aux_ram_en = fuse_security_byte[FSB_AUX_RAM];
    next_double_speed = !fuse_security_byte[FSB_DBL_SPEED];
  end

  // register everything; synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fuse_security_byte <= FSB_DEFAULT;
      loader_lock_byte <= LLB_DEFAULT;
      boot_status_byte <= BSB_DEFAULT;
      boot_vector_high <= BVH_DEFAULT;
      rsp <= '0;
      flash_wr_en <= 1'b0;
      flash_erase_all <= 1'b0;
      pin_latched <= 1'b1;
      started <= 1'b0;
      fetch_external <= 1'b0;
      table_read_block <= 1'b0;
      ext_exec_fault <= 1'b0;
      reset_vector <= BOOT_LOADER_ADDR;
      aux_ram_en <= 1'b1;
      double_speed <= 1'b0;
    end else begin
      fuse_security_byte <= next_fsb;
      loader_lock_byte <= next_llb;
      boot_status_byte <= next_bsb;
      boot_vector_high <= next_bvh;
      rsp <= next_rsp;
      flash_wr_en <= next_wr;
      flash_erase_all <= next_erase;
      pin_latched <= next_pin_latched;
      started <= next_started;
      fetch_external <= next_fetch_ext;
      table_read_block <= next_tbl_block;
      ext_exec_fault <= next_ext_fault;
      reset_vector <= next_reset_vector;
      aux_ram_en <= next_aux_ram_en;
      double_speed <= next_double_speed;
    end
  end

  // ======================================================
  // checks
  a_par_prog_lock: assert property (@(posedge clk) disable iff (!rst_n)
    req.valid && req.op == FLP_OP_PROG && req.src == FLP_SRC_PAR
    && !fuse_security_byte[FSB_LB_LOW] |=> !flash_wr_en && rsp.done && !rsp.granted)
    else $error("parallel program passed a lock");
  a_par_verify_lock: assert property (@(posedge clk) disable iff (!rst_n)
    req.valid && req.op == FLP_OP_VERIFY && req.src == FLP_SRC_PAR
    && !fuse_security_byte[FSB_LB_MID] |=> !rsp.granted)
    else $error("parallel verify passed level 3");
  a_isp_prog_lock: assert property (@(posedge clk) disable iff (!rst_n)
    req.valid && req.op == FLP_OP_PROG && req.src == FLP_SRC_ISP
    && !loader_lock_byte[LLB_LB_LOW] |=> !flash_wr_en)
    else $error("isp program passed a lock");
  a_isp_verify_lock: assert property (@(posedge clk) disable iff (!rst_n)
    req.valid && req.op == FLP_OP_VERIFY && req.src == FLP_SRC_ISP
    && !loader_lock_byte[LLB_LB_MID] |=> !rsp.granted)
    else $error("isp verify passed level 3");
  a_open_grant: assert property (@(posedge clk) disable iff (!rst_n)
    req.valid && req.op == FLP_OP_PROG && req.src == FLP_SRC_PAR
    && fuse_security_byte[FSB_LB_HIGH] && fuse_security_byte[FSB_LB_MID]
    && fuse_security_byte[FSB_LB_LOW] |=> flash_wr_en && rsp.granted)
    else $error("level 1 program refused");
  a_id_read: assert property (@(posedge clk) disable iff (!rst_n)
    req.valid && req.op == FLP_OP_ID |=> rsp.granted && rsp.rdata == PART_ID)
    else $error("part id not returned");
  a_erase_fuse: assert property (@(posedge clk) disable iff (!rst_n)
    req.valid && req.op == FLP_OP_ERASE |=> flash_erase_all
    && fuse_security_byte == FSB_ERASED)
    else $error("chip erase incomplete");
  a_ext_fault: assert property (@(posedge clk) disable iff (!rst_n)
    !fuse_security_byte[FSB_LB_HIGH] && !$past(fuse_security_byte[FSB_LB_HIGH])
    && fetch_external |-> ext_exec_fault)
    else $error("external execution not flagged at level 4");
endmodule
`default_nettype wire

// File: hw/flp_pkg.sv
// package for the flash lock protection block
`default_nettype none
package flp_pkg;
  // ======================================================
  // fuse security byte layout and defaults
  localparam int FSB_DBL_SPEED = 7;   // double speed fuse position
  localparam int FSB_LDR_JUMP = 6;    // loader jump fuse position
  localparam int FSB_AUX_RAM = 3;     // aux ram fuse position
  localparam int FSB_LB_HIGH = 2;     // lock bit high
  localparam int FSB_LB_MID = 1;      // lock bit mid
  localparam int FSB_LB_LOW = 0;      // lock bit low
  localparam logic [7:0] FSB_DEFAULT = 8'hAB;   // 101x 1011b with x taken as 0
  localparam logic [7:0] FSB_ERASED = 8'hFF;    // inactive state after chip erase
  // ======================================================
  // extra flash page software registers
  localparam logic [7:0] LLB_DEFAULT = 8'hFF;   // loader lock byte reset
  localparam logic [7:0] BSB_DEFAULT = 8'hFF;   // boot status byte reset
  localparam logic [7:0] BVH_DEFAULT = 8'hFC;   // no customer loader
  localparam logic [7:0] LLB_RSVD_MASK = 8'hFC; // reserved bits 7..2
  localparam int LLB_LB_MID = 1;      // loader lock bit mid
  localparam int LLB_LB_LOW = 0;      // loader lock bit low
  // extra flash page indexes
  localparam logic [1:0] XFP_FSB = 2'h0;
  localparam logic [1:0] XFP_LLB = 2'h1;
  localparam logic [1:0] XFP_BSB = 2'h2;
  localparam logic [1:0] XFP_BVH = 2'h3;
  // ======================================================
  // memory map
  localparam logic [15:0] TOP_16K = 16'h3FFF;
  localparam logic [15:0] TOP_32K = 16'h7FFF;
  localparam logic [15:0] BOOT_LOADER_ADDR = 16'hF800;
  localparam logic [15:0] APP_START_ADDR = 16'h0000;
  // part identification, arbitrary neutral value
  localparam logic [7:0] PART_ID = 8'h3C;
  // ======================================================
  // protection levels
  typedef enum logic [1:0] {
    FLP_LVL1 = 2'b00,
    FLP_LVL2 = 2'b01,
    FLP_LVL3 = 2'b10,
    FLP_LVL4 = 2'b11
  } flp_level_t;
  // request kinds
  typedef enum logic [2:0] {
    FLP_OP_NONE = 3'b000,
    FLP_OP_PROG = 3'b001,   // flash byte program
    FLP_OP_VERIFY = 3'b010, // flash read back
    FLP_OP_ERASE = 3'b011,  // chip erase
    FLP_OP_ID = 3'b100,     // part identification read
    FLP_OP_XFP_WR = 3'b101, // extra flash page write
    FLP_OP_XFP_RD = 3'b110  // extra flash page read
  } flp_op_t;
  // request sources
  typedef enum logic [1:0] {
    FLP_SRC_PAR = 2'b00,
    FLP_SRC_ISP = 2'b01,
    FLP_SRC_API = 2'b10
  } flp_src_t;
  // programming request bundle
  typedef struct packed {
    logic valid;
    flp_op_t op;
    flp_src_t src;
    logic [1:0] xfp_idx;
    logic [7:0] wdata;
  } flp_req_t;
  // answer bundle
  typedef struct packed {
    logic done;
    logic granted;
    logic [7:0] rdata;
  } flp_rsp_t;
endpackage
`default_nettype wire
